// file: src/srsc_pkg.sv
// Purpose: Shared constants of the supervisor reset control block
// Assumes: 250 MHz clock, APB register access with 32-bit words
// Notes: Times are kept in their own unit and turned into cycle counts here
package srsc_pkg;
  // Clock rate
  localparam int unsigned CLK_MHZ = 250;
  localparam longint unsigned CLK_HZ = 64'd250_000_000;

  // Noise rejection of the two external reset inputs
  localparam int unsigned FAST_REJECT_NS = 50;
  localparam int unsigned FAST_REJECT_CYC = (FAST_REJECT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SLOW_REJECT_MS = 20;
  localparam int unsigned SLOW_REJECT_CYC = SLOW_REJECT_MS * CLK_MHZ * 1000;

  // Recovery lengths, least values rounded up
  localparam int unsigned REC_DEF_MS = 96;
  localparam int unsigned REC_DEF_CYC = REC_DEF_MS * CLK_MHZ * 1000;
  localparam int unsigned REC_HALT_MS = 40;
  localparam int unsigned REC_HALT_CYC = REC_HALT_MS * CLK_MHZ * 1000;
  localparam int unsigned REC_SHORT_US = 50;
  localparam int unsigned REC_SHORT_CYC = REC_SHORT_US * CLK_MHZ;

  // Battery check period
  localparam int unsigned BAT_PERIOD_H = 24;
  localparam longint unsigned BAT_PERIOD_CYC = 64'(BAT_PERIOD_H) * 64'd3600 * CLK_HZ;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] WDOG_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h10;
  localparam logic [7:0] IRQ_EN_OFS = 8'h14;

  // Control register fields
  localparam int unsigned CTL_CENT_EN = 0;
  localparam int unsigned CTL_CENT_FLAG = 1;
  localparam int unsigned CTL_REC_SEL = 2;
  localparam int unsigned CTL_OSC_HALT = 3;
  localparam int unsigned CTL_OUT_LVL = 4;
  localparam int unsigned CTL_FREQ_TEST = 5;
  localparam int unsigned CTL_ALARM_IRQ = 6;
  localparam int unsigned CTL_ALARM_BKP = 7;
  localparam int unsigned CTL_SQW_EN = 8;
  localparam int unsigned CTL_HALT_UPD = 9;
  localparam int unsigned CTL_W = 10;
  localparam logic [9:0] CTL_RESET = 10'h210;

  // Status register fields
  localparam int unsigned ST_BAT_LOW = 0;
  localparam int unsigned ST_RST_ACT = 1;
  localparam int unsigned ST_REC_ACT = 2;
  localparam int unsigned ST_PFO_LVL = 3;
  localparam int unsigned ST_BACKUP = 4;

  // Interrupt event bits
  localparam int unsigned EV_EXT_RST = 0;
  localparam int unsigned EV_BAT_LOW = 1;
  localparam int unsigned EV_PWR_FAIL = 2;
  localparam int unsigned EV_CENTURY = 3;
  localparam int unsigned EV_W = 4;

  // Supervisor states
  typedef enum logic [1:0] {SV_BACKUP, SV_HOLD, SV_RECOVER, SV_RUN} srsc_state_t;
endpackage : srsc_pkg

// file: src/srsc_top.sv
// Purpose: Reset supervisor, power-fail flag, century flag and battery check
// Assumes: Supply and comparator levels arrive as digital inputs
// Notes: APB slave with zero wait states; open-drain pins as out/enable pairs
`timescale 1ns/1ps

module srsc_top
#(
  parameter int unsigned SLOW_CYC = srsc_pkg::SLOW_REJECT_CYC,
  parameter int unsigned REC_DEF = srsc_pkg::REC_DEF_CYC,
  parameter int unsigned REC_HALT = srsc_pkg::REC_HALT_CYC,
  parameter int unsigned REC_SHORT = srsc_pkg::REC_SHORT_CYC,
  parameter longint unsigned BAT_CYC = srsc_pkg::BAT_PERIOD_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_reset_fast_in,
  input wire logic ext_reset_slow_in,
  input wire logic powerfail_sense_in,
  input wire logic supply_ok_in,
  input wire logic supply_backup_in,
  input wire logic battery_ok_in,
  input wire logic century_rollover_in,
  output logic cpu_reset_o,
  output logic cpu_reset_oe,
  output logic powerfail_flag_n,
  output logic combined_irq_pin_o,
  output logic combined_irq_pin_oe,
  output logic irq
);
  import srsc_pkg::*;

  localparam int unsigned NSYNC = 6;

  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  logic fast_n;
  logic slow_n;
  logic sense_hi;
  logic sup_ok;
  logic sup_bkp;
  logic bat_ok;
  logic [3:0] fast_cnt_q;
  logic fast_req_q;
  logic [31:0] slow_cnt_q;
  logic slow_req_q;
  logic ext_req;
  logic [1:0] edge_prev_q;
  srsc_state_t state_q;
  logic [31:0] rec_cnt_q;
  logic [31:0] rec_len;
  logic pwr_rec_q;
  logic powered_before_q;
  logic power_up;
  logic [CTL_W-1:0] ctl_q;
  logic [7:0] wdog_q;
  logic bat_low_q;
  logic [47:0] bat_cnt_q;
  logic bat_test;
  logic pfo_q;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] irq_stat_q;
  logic [EV_W-1:0] irq_en_q;
  logic acc;
  logic wr;
  logic wr_block;
  logic addr_ok;
  logic cause;
  logic roll;

  // Level inputs other than the fast reset pass two flip-flops before any use
  assign raw_in = {century_rollover_in, battery_ok_in, supply_backup_in, supply_ok_in,
                   powerfail_sense_in, ext_reset_slow_in};
  for (genvar i = 0; i < NSYNC; i++)
  begin : g_sync
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
      end
      else
      begin
        sync1_q[i] <= raw_in[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  // Fast input is filtered directly to keep the short window precise
  assign fast_n = ~ext_reset_fast_in;
  assign slow_n = ~sync2_q[0];
  assign sense_hi = sync2_q[1];
  assign sup_ok = sync2_q[2];
  assign sup_bkp = sync2_q[3];
  assign bat_ok = sync2_q[4];
  assign roll = sync2_q[5] & ~edge_prev_q[1];

  // Fast reset filter: low must persist past the rejection window
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fast_cnt_q <= 4'h0;
      fast_req_q <= 1'b0;
    end
    else if (!fast_n)
    begin
      fast_cnt_q <= 4'h0;
      fast_req_q <= 1'b0;
    end
    else if (fast_cnt_q == 4'(FAST_REJECT_CYC - 1))
      fast_req_q <= 1'b1;
    else
      fast_cnt_q <= fast_cnt_q + 4'h1;
  end

  // Slow reset filter, same scheme with a long window
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slow_cnt_q <= 32'h0000_0000;
      slow_req_q <= 1'b0;
    end
    else if (!slow_n)
    begin
      slow_cnt_q <= 32'h0000_0000;
      slow_req_q <= 1'b0;
    end
    else if (slow_cnt_q == SLOW_CYC - 1)
      slow_req_q <= 1'b1;
    else
      slow_cnt_q <= slow_cnt_q + 32'h0000_0001;
  end

  assign ext_req = fast_req_q | slow_req_q;
  assign cause = ~sup_ok | ext_req;

  // Recovery length from the select and halt bits
  always_comb
  begin
    if (ctl_q[CTL_REC_SEL])
      rec_len = REC_SHORT;
    else if (ctl_q[CTL_OSC_HALT])
      rec_len = REC_HALT;
    else
      rec_len = REC_DEF;
  end

  // Supervisor sequence: backup, hold, recovery count, run
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= SV_BACKUP;
      rec_cnt_q <= 32'h0000_0000;
    end
    else if (sup_bkp)
      state_q <= SV_BACKUP;
    else if (cause)
      state_q <= SV_HOLD;
    else
    begin
      case (state_q)
        SV_BACKUP, SV_HOLD:
        begin
          state_q <= SV_RECOVER;
          rec_cnt_q <= 32'h0000_0000;
        end
        SV_RECOVER:
        begin
          if (rec_cnt_q >= rec_len - 1)
            state_q <= SV_RUN;
          else
            rec_cnt_q <= rec_cnt_q + 32'h0000_0001;
        end
        SV_RUN: state_q <= SV_RUN;
        default: state_q <= SV_HOLD;
      endcase
    end
  end

  // Power recovery marker, set from backup until the first run
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwr_rec_q <= 1'b1;
    else if (sup_bkp || !sup_ok)
      pwr_rec_q <= 1'b1;
    else if (state_q == SV_RUN)
      pwr_rec_q <= 1'b0;
  end

  assign power_up = (state_q == SV_BACKUP) && !sup_bkp;

  // Reset pin is pulled low in every state but run
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cpu_reset_oe <= 1'b1;
    else
      cpu_reset_oe <= (state_q != SV_RUN);
  end
  assign cpu_reset_o = 1'b0;

  // Power-fail flag: low in backup, high while power recovers, else comparator
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pfo_q <= 1'b0;
    else if (state_q == SV_BACKUP)
      pfo_q <= 1'b0;
    else if (pwr_rec_q)
      pfo_q <= 1'b1;
    else
      pfo_q <= sense_hi;
  end
  assign powerfail_flag_n = pfo_q;

  // First power-up after battery attach is told apart from later ones
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      powered_before_q <= 1'b0;
    else if (power_up)
      powered_before_q <= 1'b1;
  end

  // Writes are refused while power is recovering
  assign acc = psel & penable;
  assign wr_block = pwr_rec_q;
  assign wr = acc & pwrite & ~wr_block & addr_ok;

  // Control register with power-up defaults and century toggle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctl_q <= CTL_RESET;
    else if (power_up)
    begin
      ctl_q[CTL_HALT_UPD] <= 1'b1;
      ctl_q[CTL_FREQ_TEST] <= 1'b0;
      ctl_q[CTL_ALARM_IRQ] <= 1'b0;
      ctl_q[CTL_ALARM_BKP] <= 1'b0;
      ctl_q[CTL_SQW_EN] <= 1'b0;
      if (!powered_before_q)
      begin
        ctl_q[CTL_REC_SEL] <= 1'b0;
        ctl_q[CTL_OSC_HALT] <= 1'b0;
        ctl_q[CTL_OUT_LVL] <= 1'b1;
      end
    end
    else if (wr && paddr == CTRL_OFS)
    begin
      ctl_q <= pwdata[CTL_W-1:0];
      ctl_q[CTL_CENT_FLAG] <= pwdata[CTL_CENT_FLAG] ^ (roll & pwdata[CTL_CENT_EN]);
    end
    else if (roll && ctl_q[CTL_CENT_EN])
      ctl_q[CTL_CENT_FLAG] <= ~ctl_q[CTL_CENT_FLAG];
  end

  // Watchdog setting register, cleared at every power-up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wdog_q <= 8'h00;
    else if (power_up)
      wdog_q <= 8'h00;
    else if (wr && paddr == WDOG_OFS)
      wdog_q <= pwdata[7:0];
  end

  // Daily battery check timer, runs only on main supply
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bat_cnt_q <= 48'h0000_0000_0000;
    else if (state_q == SV_BACKUP || !sup_ok || bat_test)
      bat_cnt_q <= 48'h0000_0000_0000;
    else
      bat_cnt_q <= bat_cnt_q + 48'h0000_0000_0001;
  end

  // Test at the end of power recovery and at each daily expiry
  assign bat_test = sup_ok && !sup_bkp &&
                    ((pwr_rec_q && state_q == SV_RUN) ||
                     bat_cnt_q == 48'(BAT_CYC - 1));

  // Battery-low flag changes only on a test result
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bat_low_q <= 1'b0;
    else if (bat_test)
      bat_low_q <= ~bat_ok;
  end

  // Combined pin acts as plain output when its other uses are idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      combined_irq_pin_oe <= 1'b0;
    else
      combined_irq_pin_oe <= ~ctl_q[CTL_FREQ_TEST] & ~ctl_q[CTL_ALARM_IRQ] &
                             (wdog_q == 8'h00) & ~ctl_q[CTL_OUT_LVL];
  end
  assign combined_irq_pin_o = 1'b0;

  // Event sources for the interrupt status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      edge_prev_q <= 2'b00;
    else
      edge_prev_q <= {sync2_q[5], ext_req};
  end
  assign ev[EV_EXT_RST] = ext_req & ~edge_prev_q[0];
  assign ev[EV_BAT_LOW] = bat_test & ~bat_ok;
  assign ev[EV_PWR_FAIL] = (state_q != SV_BACKUP) & ~pwr_rec_q & pfo_q & ~sense_hi;
  assign ev[EV_CENTURY] = roll & ctl_q[CTL_CENT_EN];

  // Sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_q <= '0;
    else if (wr && paddr == IRQ_CLR_OFS)
      irq_stat_q <= (irq_stat_q & ~pwdata[EV_W-1:0]) | ev;
    else
      irq_stat_q <= irq_stat_q | ev;
  end

  // Interrupt enable register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_en_q <= '0;
    else if (wr && paddr == IRQ_EN_OFS)
      irq_en_q <= pwdata[EV_W-1:0];
  end

  assign irq = |(irq_stat_q & irq_en_q);

  // Address decode
  always_comb
  begin
    case (paddr)
      CTRL_OFS, WDOG_OFS, STAT_OFS, IRQ_STAT_OFS, IRQ_CLR_OFS, IRQ_EN_OFS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Zero wait states; error on unmapped address or refused write
  assign pready = 1'b1;
  assign pslverr = acc & (~addr_ok | (pwrite & wr_block));

  // Read data is captured in the setup cycle and shown in the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
    begin
      case (paddr)
        CTRL_OFS: prdata <= {22'h00_0000, ctl_q};
        WDOG_OFS: prdata <= {24'h00_0000, wdog_q};
        STAT_OFS: prdata <= {27'h000_0000, (state_q == SV_BACKUP), pfo_q,
                             (state_q == SV_RECOVER), (state_q != SV_RUN), bat_low_q};
        IRQ_STAT_OFS: prdata <= {28'h000_0000, irq_stat_q};
        IRQ_EN_OFS: prdata <= {28'h000_0000, irq_en_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : srsc_top

// file: verification/srsc_properties.sv
// Purpose: Port timing properties of the supervisor reset control block
// Assumes: Counts equal the parameters of the bound top
// Notes: Bound to srsc_top below the module
`timescale 1ns/1ps
module srsc_properties
#(
  parameter int unsigned SLOW_CYC = 20,
  parameter int unsigned REC_DEF = 50,
  parameter int unsigned REC_SHORT = 10
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pslverr,
  input wire logic ext_reset_fast_in,
  input wire logic ext_reset_slow_in,
  input wire logic powerfail_sense_in,
  input wire logic supply_ok_in,
  input wire logic supply_backup_in,
  input wire logic cpu_reset_oe,
  input wire logic powerfail_flag_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] fast_cnt_q;
  int unsigned slow_cnt_q;
  int unsigned quiet_q;
  logic pwr_rec_q;
  // Low run lengths of the reset inputs and time since every cause went away
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fast_cnt_q <= 4'h0;
      slow_cnt_q <= 0;
      quiet_q <= 0;
    end
    else
    begin
      fast_cnt_q <= ext_reset_fast_in ? 4'h0 : fast_cnt_q + 4'(fast_cnt_q != 4'hf);
      slow_cnt_q <= ext_reset_slow_in ? 0 : slow_cnt_q + 32'(slow_cnt_q < SLOW_CYC);
      if (fast_cnt_q >= 4'd13 || slow_cnt_q >= SLOW_CYC || !supply_ok_in || supply_backup_in)
        quiet_q <= 0;
      else
        quiet_q <= quiet_q + 32'(quiet_q < 4000);
    end
  end
  // Marks a recovery that follows a supply loss
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwr_rec_q <= 1'b1;
    else if (supply_backup_in || !supply_ok_in)
      pwr_rec_q <= 1'b1;
    else if (!cpu_reset_oe)
      pwr_rec_q <= 1'b0;
  end
  property p_fast_acc;
    fast_cnt_q == 4'd13 |-> ##[0:3] cpu_reset_oe;
  endproperty
  a_fast_acc: assert property (p_fast_acc) else $error("fast reset not taken");
  property p_fast_rej;
    (!cpu_reset_oe && fast_cnt_q < 4'd12 && ext_reset_slow_in && supply_ok_in
      && !supply_backup_in) [*6] |=> !cpu_reset_oe;
  endproperty
  a_fast_rej: assert property (p_fast_rej) else $error("reset without cause");
  property p_slow_acc;
    slow_cnt_q == SLOW_CYC |-> ##[0:6] cpu_reset_oe;
  endproperty
  a_slow_acc: assert property (p_slow_acc) else $error("slow reset not taken");
  property p_release;
    $fell(cpu_reset_oe) |-> quiet_q >= REC_SHORT - 1 && quiet_q <= REC_DEF + 12;
  endproperty
  a_release: assert property (p_release) else $error("release time off");
  property p_backup;
    supply_backup_in [*5] |-> !powerfail_flag_n && cpu_reset_oe;
  endproperty
  a_backup: assert property (p_backup) else $error("backup outputs wrong");
  property p_supply_low;
    !supply_ok_in [*5] |-> cpu_reset_oe;
  endproperty
  a_supply_low: assert property (p_supply_low) else $error("reset not held");
  property p_forced_hi;
    (pwr_rec_q && supply_ok_in && !supply_backup_in) [*6] ##0 cpu_reset_oe ##2 cpu_reset_oe
      |-> $past(powerfail_flag_n, 2);
  endproperty
  a_forced_hi: assert property (p_forced_hi) else $error("flag not forced high");
  property p_follow;
    (!cpu_reset_oe && $stable(powerfail_sense_in)) [*4] |-> powerfail_flag_n == powerfail_sense_in;
  endproperty
  a_follow: assert property (p_follow) else $error("flag not following");
  property p_bkp_wr;
    supply_backup_in [*4] ##0 (psel && penable && pwrite) |-> pslverr;
  endproperty
  a_bkp_wr: assert property (p_bkp_wr) else $error("write taken in backup");
  c_rst: cover property ($rose(cpu_reset_oe) && supply_ok_in);
  c_rel: cover property ($fell(cpu_reset_oe));
  c_err: cover property (psel && penable && pslverr);
endmodule : srsc_properties

bind srsc_top srsc_properties #(.SLOW_CYC(SLOW_CYC), .REC_DEF(REC_DEF), .REC_SHORT(REC_SHORT))
  u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pslverr(pslverr), .ext_reset_fast_in(ext_reset_fast_in),
  .ext_reset_slow_in(ext_reset_slow_in), .powerfail_sense_in(powerfail_sense_in),
  .supply_ok_in(supply_ok_in), .supply_backup_in(supply_backup_in),
  .cpu_reset_oe(cpu_reset_oe), .powerfail_flag_n(powerfail_flag_n));

// file: verification/srsc_host_model.sv
// Purpose: Host side: reset sources and pulled-up open-drain lines
// Assumes: Both reset inputs idle high through pull-ups
// Notes: Pulses are commanded by the bench
`timescale 1ns/1ps
module srsc_host_model
(
  input wire logic pclk,
  input wire logic cpu_reset_o,
  input wire logic cpu_reset_oe,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic ext_reset_fast_in,
  output logic ext_reset_slow_in,
  output logic rst_line,
  output logic irq_line
);
  // Pull-ups resolve both open-drain lines
  assign rst_line = cpu_reset_oe ? cpu_reset_o : 1'b1;
  assign irq_line = pin_oe ? pin_o : 1'b1;
  // Sources rest high
  initial
  begin
    ext_reset_fast_in = 1'b1;
    ext_reset_slow_in = 1'b1;
  end
  // One source held low for n cycles
  task automatic low_pulse(input bit slow, input int n);
    if (slow)
      ext_reset_slow_in <= 1'b0;
    else
      ext_reset_fast_in <= 1'b0;
    repeat (n) @(posedge pclk);
    ext_reset_fast_in <= 1'b1;
    ext_reset_slow_in <= 1'b1;
  endtask : low_pulse
endmodule : srsc_host_model

// file: verification/testbench.sv
// Purpose: Self-checking bench of the supervisor reset control block
// Assumes: Short counts set through the top's parameters
// Notes: Reset sources and open-drain lines live in the host model
`timescale 1ns/1ps
module testbench;
  import srsc_pkg::*;
  localparam int unsigned SLW = 20;
  localparam int unsigned RDEF = 50;
  localparam int unsigned RHLT = 30;
  localparam int unsigned RSHT = 10;
  localparam longint unsigned BAT = 200;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic sense = 1'b0;
  logic sup_ok = 1'b1;
  logic bkp = 1'b0;
  logic bat_ok = 1'b1;
  logic roll = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, fast_n, slow_n, rst_o, rst_oe, pf_n, pin_o, pin_oe, irq;
  logic rst_line, irq_line;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  srsc_top #(.SLOW_CYC(SLW), .REC_DEF(RDEF), .REC_HALT(RHLT), .REC_SHORT(RSHT),
    .BAT_CYC(BAT)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_reset_fast_in(fast_n), .ext_reset_slow_in(slow_n),
    .powerfail_sense_in(sense), .supply_ok_in(sup_ok), .supply_backup_in(bkp),
    .battery_ok_in(bat_ok), .century_rollover_in(roll), .cpu_reset_o(rst_o),
    .cpu_reset_oe(rst_oe), .powerfail_flag_n(pf_n), .combined_irq_pin_o(pin_o),
    .combined_irq_pin_oe(pin_oe), .irq(irq));
  srsc_host_model host (.pclk(pclk), .cpu_reset_o(rst_o), .cpu_reset_oe(rst_oe),
    .pin_o(pin_o), .pin_oe(pin_oe), .ext_reset_fast_in(fast_n),
    .ext_reset_slow_in(slow_n), .rst_line(rst_line), .irq_line(irq_line));
  always #2 pclk = ~pclk;
  task automatic test_done;
    if (fails == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  // Cuts a hang short
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      fails++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic x);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk(32'(e), 32'(x));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, x);
  endtask : rd
  // Waits for release and checks the recovery length
  task automatic rel(input int base, input int r);
    int k;
    k = base;
    while (rst_oe !== 1'b0 && k < 3000)
    begin
      @(posedge pclk);
      k++;
    end
    chk(32'(k >= r && k <= r + 12), 32'h0000_0001);
  endtask : rel
  task automatic t_boot;
    wr(CTRL_OFS, 32'h0000_0000, 1'b1);
    rd(CTRL_OFS, 32'h0000_0210);
    chk(32'(pf_n), 32'h0000_0001);
    rel(4, RDEF);
    repeat (4) @(posedge pclk);
    chk(32'(pf_n), 32'h0000_0000);
    sense <= 1'b1;
    wr(IRQ_CLR_OFS, 32'h0000_000f, 1'b0);
  endtask : t_boot
  task automatic t_fast;
    int unsigned rec [3] = '{RSHT, RHLT, RDEF};
    logic [31:0] ctl [3] = '{32'h0000_0214, 32'h0000_0218, 32'h0000_0210};
    wr(IRQ_EN_OFS, 32'h0000_0001, 1'b0);
    host.low_pulse(1'b0, 11);
    repeat (4) @(posedge pclk);
    chk(32'(rst_line), 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000);
    for (int i = 0; i < 3; i++)
    begin
      wr(CTRL_OFS, ctl[i], 1'b0);
      host.low_pulse(1'b0, 50);
      chk(32'(rst_line), 32'h0000_0000);
      rel(0, rec[i]);
    end
    chk(32'(irq), 32'h0000_0001);
    wr(IRQ_EN_OFS, 32'h0000_0000, 1'b0);
    chk(32'(irq), 32'h0000_0000);
    wr(IRQ_EN_OFS, 32'h0000_0001, 1'b0);
    wr(IRQ_CLR_OFS, 32'h0000_0001, 1'b0);
    @(posedge pclk);
    chk(32'(irq), 32'h0000_0000);
  endtask : t_fast
  task automatic t_slow;
    host.low_pulse(1'b1, 10);
    repeat (6) @(posedge pclk);
    chk(32'(rst_line), 32'h0000_0001);
    host.low_pulse(1'b1, 100);
    chk(32'(rst_line), 32'h0000_0000);
    rel(0, RDEF);
  endtask : t_slow
  task automatic t_cent_pin;
    for (int en = 1; en >= 0; en--)
    begin
      wr(CTRL_OFS, 32'h0000_0210 | 32'(en), 1'b0);
      roll <= 1'b1;
      repeat (2) @(posedge pclk);
      roll <= 1'b0;
      repeat (4) @(posedge pclk);
      rd(CTRL_OFS, 32'h0000_0210 | 32'(en * 3));
    end
    wr(CTRL_OFS, 32'h0000_0200, 1'b0);
    repeat (2) @(posedge pclk);
    chk(32'(irq_line), 32'h0000_0000);
    wr(CTRL_OFS, 32'h0000_0220, 1'b0);
    repeat (2) @(posedge pclk);
    chk(32'(irq_line), 32'h0000_0001);
    wr(CTRL_OFS, 32'h0000_0210, 1'b0);
    repeat (2) @(posedge pclk);
    chk(32'(irq_line), 32'h0000_0001);
  endtask : t_cent_pin
  task automatic t_battery;
    bat_ok <= 1'b0;
    repeat (BAT + 20) @(posedge pclk);
    rd(STAT_OFS, 32'h0000_0009);
    wr(CTRL_OFS, 32'h0000_03ec, 1'b0);
    wr(WDOG_OFS, 32'h0000_0005, 1'b0);
    sup_ok <= 1'b0;
    bkp <= 1'b1;
    bat_ok <= 1'b1;
    sense <= 1'b0;
    repeat (BAT + 50) @(posedge pclk);
    wr(CTRL_OFS, 32'h0000_0000, 1'b1);
    chk(32'({pf_n, rst_line}), 32'h0000_0000);
    rd(STAT_OFS, 32'h0000_0013);
    sup_ok <= 1'b1;
    bkp <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(32'(pf_n), 32'h0000_0001);
    rel(6, RSHT);
    rd(CTRL_OFS, 32'h0000_020c);
    rd(WDOG_OFS, 32'h0000_0000);
    chk(32'(irq_line), 32'h0000_0000);
    rd(STAT_OFS, 32'h0000_0000);
  endtask : t_battery
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_boot();
    t_fast();
    t_slow();
    t_cent_pin();
    t_battery();
    test_done();
  end
endmodule : testbench
